// ===== rtl/watch_timer_map.svh
// register map, field layout, reset values and divider figures of the watch timer
//
// Overview of operation
// R1 - watch interrupt every 0.5 s from 4.19 MHz main or 32.768 kHz sub clock
// R2 - watch interrupt every 1.0 s from sub clock when half-rate select is set
// R3 - watch and interval functions run together, each with its own interrupt
// R4 - 9-bit prescaler on the watch clock feeds one separately controlled 5-bit counter
// R5 - clock select 0 takes main clock over 128, 1 takes sub clock or half
// R6 - interval codes 000 to 101 give 2^4 to 2^9 watch clocks; others forbidden
// R7 - counter run 1 starts the 5-bit counter, 0 stops and clears it
// R8 - timer enable 0 stops everything and clears prescaler and counter
// R9 - half-rate select 0 gives 0.5 s, 1 gives 1.0 s watch interrupt
// R10 - half-rate select acts only while clock select bit 7 is 1
// R11 - reset clears both control registers, timer stopped on divided main clock
// R12 - software should use sub clock, not 5.0 MHz main, for 0.5 s
// R13 - clearing only counter run leaves prescaler running; first interrupt may be late; here it comes up to 511 watch clocks early
// R14 - counter starts counting one prescaler period after enable; first interrupt late
// R15 - watch interrupt on 5-bit counter overflow, every 2^14 watch clocks
// R16 - unused register bits read zero and ignore writes
`ifndef WATCH_TIMER_MAP_SVH
`define WATCH_TIMER_MAP_SVH

// register indices; byte address is four times the index
`define WT_IDX_MODE 16'hFF4A
`define WT_IDX_TSEL 16'hFF4B
`define WT_IDX_STAT 16'hFF4C
`define WT_IDX_CLR 16'hFF4D
`define WT_IDX_IEN 16'hFF4E
`define WT_ADDR_W 18

// field positions
`define WT_MODE_CLKSEL 7
`define WT_MODE_IVL_HI 6
`define WT_MODE_IVL_LO 4
`define WT_MODE_RUN 1
`define WT_MODE_EN 0
`define WT_TSEL_HALF 0
`define WT_IRQ_WATCH 0
`define WT_IRQ_IVL 1

// writable bits and reset values
`define WT_MODE_MASK 8'hF3
`define WT_TSEL_MASK 8'h01
`define WT_IRQ_MASK 8'h03
`define WT_RESET_VAL 8'h00

// dividers and widths
`define WT_MAIN_DIV 128
`define WT_PRESC_W 9
`define WT_CNT_W 5
`define WT_IVL_BASE 4
`define WT_IVL_MAX 3'h5

// bus answers
`define WT_RESP_OKAY 2'h0
`define WT_RESP_SLVERR 2'h2

`endif

// ===== rtl/watch_timer_pkg.sv
// types shared by the watch timer modules
package watch_timer_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [1:0] axi_resp_t;
    typedef logic [2:0] ivl_code_t;
    typedef enum logic [1:0] {SRC_MAIN_DIV, SRC_SUB, SRC_SUB_HALF} clk_src_t;
endpackage

// ===== rtl/watch_link_if.sv
// signals between the register top, the clock generator and the counting core
`timescale 1ns/1ps
interface watch_link_if;
    import watch_timer_pkg::*;
    clk_src_t src;
    logic watch_tick;
    logic timer_enable;
    logic counter_run;
    ivl_code_t interval_code;
    logic watch_evt;
    logic interval_evt;
    modport gen (input src, output watch_tick);
    modport core (input watch_tick, timer_enable, counter_run, interval_code,
                  output watch_evt, interval_evt);
endinterface

// ===== rtl/watch_clock_gen.sv
// watch clock tick: main clock over 128, or sub clock pin, or half of it
`timescale 1ns/1ps
`include "watch_timer_map.svh"
module watch_clock_gen #(
    parameter int MAIN_DIV = `WT_MAIN_DIV
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // sub clock pin, asynchronous
    input wire logic sub_clk_pin,
    // link to the counting core
    watch_link_if.gen link
);
    import watch_timer_pkg::*;
    localparam int DW = $clog2(MAIN_DIV);

    generate
        if (MAIN_DIV < 2 || (1 << DW) != MAIN_DIV) begin : g_chk
            $error("main divider must be a power of two of at least 2");
        end
    endgenerate

    logic [DW-1:0] main_div_reg;
    logic sub_meta_reg, sub_sync_reg, sub_last_reg;
    logic half_reg;
    logic main_tick, sub_rise;

    // free running divider; core_clk is the main clock
    always_ff @(posedge core_clk) begin
        if (!nrst) main_div_reg <= '0;
        else main_div_reg <= main_div_reg + 1'b1;
    end
    assign main_tick = &main_div_reg;

    // two flops before use, third only for the edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_last_reg <= 1'b0;
        end else begin
            sub_meta_reg <= sub_clk_pin;
            sub_sync_reg <= sub_meta_reg;
            sub_last_reg <= sub_sync_reg;
        end
    end
    assign sub_rise = sub_sync_reg & ~sub_last_reg;

    // R2 half rate toggle
    always_ff @(posedge core_clk) begin
        if (!nrst) half_reg <= 1'b0;
        else if (sub_rise) half_reg <= ~half_reg;
    end

    // R5 source choice
    always_comb begin
        unique case (link.src)
            SRC_MAIN_DIV: link.watch_tick = main_tick;
            SRC_SUB: link.watch_tick = sub_rise;
            SRC_SUB_HALF: link.watch_tick = sub_rise & half_reg;
            default: link.watch_tick = 1'b0;
        endcase
    end
endmodule

// ===== rtl/watch_count_core.sv
// 9-bit prescaler, interval event and 5-bit watch counter
`timescale 1ns/1ps
`include "watch_timer_map.svh"
module watch_count_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link from the top and the clock generator
    watch_link_if.core link
);
    import watch_timer_pkg::*;

    logic [`WT_PRESC_W-1:0] presc_reg;
    logic [`WT_CNT_W-1:0] cnt_reg;
    logic primed_reg;
    logic watch_evt_reg, interval_evt_reg;
    logic presc_wrap;
    ivl_code_t code_c;
    logic [`WT_PRESC_W-1:0] ivl_mask;

    // R8 prescaler cleared while disabled
    always_ff @(posedge core_clk) begin
        if (!nrst || !link.timer_enable) presc_reg <= '0;
        else if (link.watch_tick) presc_reg <= presc_reg + 1'b1;
    end
    assign presc_wrap = link.watch_tick & (&presc_reg);

    // R6 forbidden codes fall back to the longest interval
    assign code_c = (link.interval_code > `WT_IVL_MAX) ? `WT_IVL_MAX : link.interval_code;
    assign ivl_mask = {`WT_PRESC_W{1'b1}} >> (`WT_IVL_MAX - code_c);

    // R3 interval event independent of counter run
    always_ff @(posedge core_clk) begin
        if (!nrst) interval_evt_reg <= 1'b0;
        else interval_evt_reg <= link.timer_enable & link.watch_tick
                                 & ((presc_reg & ivl_mask) == ivl_mask);
    end

    // R14 first prescaler period after enable only arms the counter
    always_ff @(posedge core_clk) begin
        if (!nrst || !link.timer_enable) primed_reg <= 1'b0;
        else if (presc_wrap) primed_reg <= 1'b1;
    end

    // R7 counter cleared while not running; R13 prescaler untouched here
    always_ff @(posedge core_clk) begin
        if (!nrst || !link.timer_enable || !link.counter_run) cnt_reg <= '0;
        else if (presc_wrap && primed_reg) cnt_reg <= cnt_reg + 1'b1;
    end

    // R15 overflow of the 5-bit counter
    always_ff @(posedge core_clk) begin
        if (!nrst) watch_evt_reg <= 1'b0;
        else watch_evt_reg <= link.timer_enable & link.counter_run & presc_wrap
                              & primed_reg & (&cnt_reg);
    end

    assign link.watch_evt = watch_evt_reg;
    assign link.interval_evt = interval_evt_reg;
endmodule

// ===== rtl/watch_interval_timer.sv
// watch and interval timer top with its axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "watch_timer_map.svh"
module watch_interval_timer #(
    parameter int ADDR_W = `WT_ADDR_W,
    parameter int MAIN_DIV = `WT_MAIN_DIV
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output watch_timer_pkg::axi_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output watch_timer_pkg::axi_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sub clock pin
    input wire logic sub_clk_pin,
    // events and interrupt
    output logic watch_irq,
    output logic interval_irq,
    output logic irq
);
    import watch_timer_pkg::*;
    localparam int IDX_W = ADDR_W - 2;
    localparam logic [IDX_W-1:0] IDX_MODE = IDX_W'(`WT_IDX_MODE);
    localparam logic [IDX_W-1:0] IDX_TSEL = IDX_W'(`WT_IDX_TSEL);
    localparam logic [IDX_W-1:0] IDX_STAT = IDX_W'(`WT_IDX_STAT);
    localparam logic [IDX_W-1:0] IDX_CLR = IDX_W'(`WT_IDX_CLR);
    localparam logic [IDX_W-1:0] IDX_IEN = IDX_W'(`WT_IDX_IEN);

    generate
        if (ADDR_W < `WT_ADDR_W || ADDR_W > 32) begin : g_chk
            $error("address width must hold the register map and stay within 32");
        end
    endgenerate

    // software visible state
    reg8_t mode_reg;
    reg8_t tsel_reg;
    reg8_t status_reg;
    reg8_t ien_reg;

    // write channel holding state
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [IDX_W-1:0] aw_idx_reg;
    logic [7:0] w_byte_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    axi_resp_t bresp_reg;

    // read channel state
    logic rvalid_reg;
    axi_resp_t rresp_reg;
    logic [31:0] rdata_reg;

    // decoded write strobes
    logic do_write;
    logic wr_mode;
    logic wr_tsel;
    logic wr_clr;
    logic wr_ien;
    logic wr_hit;
    reg8_t clr_bits;
    reg8_t evt_bits;
    reg8_t status_next;
    reg8_t ien_next;

    // registered interrupt level
    logic irq_reg;

    // read decode
    logic [IDX_W-1:0] rd_idx;
    logic rd_hit;
    reg8_t rd_byte;

    watch_link_if link ();

    // ready only while the channel slot is empty and no response pends
    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
    assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;

    // write address slot, taken independently of data
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    // word index; byte offset bits carry nothing here
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            aw_idx_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
        end
    end

    // write data slot
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            w_hold_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    // data byte and lane; registers are 8 bits in lane 0
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            w_byte_reg <= `WT_RESET_VAL;
            w_lane0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
        end
    end

    // write decode; a strobe without lane 0 changes nothing but still answers
    assign wr_mode = do_write & w_lane0_reg & (aw_idx_reg == IDX_MODE);
    assign wr_tsel = do_write & w_lane0_reg & (aw_idx_reg == IDX_TSEL);
    assign wr_clr = do_write & w_lane0_reg & (aw_idx_reg == IDX_CLR);
    assign wr_ien = do_write & w_lane0_reg & (aw_idx_reg == IDX_IEN);

    // mapped address hit for the write answer
    always_comb begin
        unique case (aw_idx_reg)
            IDX_MODE, IDX_TSEL, IDX_STAT, IDX_CLR, IDX_IEN: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response; status is read-only but a write there is harmless
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // response code, held until the next write completes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bresp_reg <= `WT_RESP_OKAY;
        end else if (do_write) begin
            bresp_reg <= wr_hit ? `WT_RESP_OKAY : `WT_RESP_SLVERR;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // R11 R16 mode register, reset to zero, unused bits masked
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_reg <= `WT_RESET_VAL;
        end else if (wr_mode) begin
            mode_reg <= w_byte_reg & `WT_MODE_MASK;
        end
    end

    // R11 R16 interrupt time select register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tsel_reg <= `WT_RESET_VAL;
        end else if (wr_tsel) begin
            tsel_reg <= w_byte_reg & `WT_TSEL_MASK;
        end
    end

    // interrupt enable register
    assign ien_next = wr_ien ? (w_byte_reg & `WT_IRQ_MASK) : ien_reg;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ien_reg <= `WT_RESET_VAL;
        end else begin
            ien_reg <= ien_next;
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_comb begin
        clr_bits = wr_clr ? (w_byte_reg & `WT_IRQ_MASK) : `WT_RESET_VAL;
        evt_bits = `WT_RESET_VAL;
        evt_bits[`WT_IRQ_WATCH] = link.watch_evt;
        evt_bits[`WT_IRQ_IVL] = link.interval_evt;
        status_next = (status_reg & ~clr_bits) | evt_bits;
    end

    // status takes the merged set and clear
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            status_reg <= `WT_RESET_VAL;
        end else begin
            status_reg <= status_next;
        end
    end

    // level interrupt from a flop; next values keep it in step with status
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & ien_next);
        end
    end
    assign irq = irq_reg;
    assign watch_irq = link.watch_evt;
    assign interval_irq = link.interval_evt;

    // read decode; clear register is write-only and reads zero
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_idx)
            IDX_MODE: rd_byte = mode_reg;
            IDX_TSEL: rd_byte = tsel_reg;
            IDX_STAT: rd_byte = status_reg;
            IDX_CLR: rd_byte = `WT_RESET_VAL;
            IDX_IEN: rd_byte = ien_reg;
            default: begin
                rd_byte = `WT_RESET_VAL;
                rd_hit = 1'b0;
            end
        endcase
    end

    // one read at a time; address taken only while no data pends
    assign s_axi_arready = ~rvalid_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // read answer captured at accept, stable while rvalid stands
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rresp_reg <= `WT_RESP_OKAY;
            rdata_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rresp_reg <= rd_hit ? `WT_RESP_OKAY : `WT_RESP_SLVERR;
            rdata_reg <= {24'h000000, rd_byte};
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // R5 R9 R10 source: half-rate select only counts on the sub clock
    always_comb begin
        if (!mode_reg[`WT_MODE_CLKSEL]) link.src = SRC_MAIN_DIV;
        else if (tsel_reg[`WT_TSEL_HALF]) link.src = SRC_SUB_HALF;
        else link.src = SRC_SUB;
    end

    // R8 R7 R6 control bits into the counting core
    assign link.timer_enable = mode_reg[`WT_MODE_EN];
    assign link.counter_run = mode_reg[`WT_MODE_RUN];
    assign link.interval_code = mode_reg[`WT_MODE_IVL_HI:`WT_MODE_IVL_LO];

    // R1 R2 watch clock from main divider or sub clock pin
    watch_clock_gen #(
        .MAIN_DIV(MAIN_DIV)
    ) u_clock_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .sub_clk_pin(sub_clk_pin),
        .link(link.gen)
    );

    // R4 R3 prescaler, interval and watch counting
    watch_count_core u_count_core (
        .core_clk(core_clk),
        .nrst(nrst),
        .link(link.core)
    );
endmodule

// ===== sim/watch_timer_props.sv
// bus handshake, reset and interrupt pulse checks for the watch timer top
`timescale 1ns/1ps
module watch_timer_props #(
    parameter int ADDR_W = 18,
    parameter int MAIN_DIV = 128
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire watch_timer_pkg::axi_resp_t s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire watch_timer_pkg::axi_resp_t s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sub clock and events
    input wire logic sub_clk_pin,
    input wire logic watch_irq,
    input wire logic interval_irq,
    input wire logic irq
);
    import watch_timer_pkg::*;
    // one clock domain, reset disables all but the reset check
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    reset_clears_a: assert property (disable iff (1'b0)
        !nrst |=> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("outputs not cleared");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held after accept");
    wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after accept");
    wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    rdata_unused_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("unused read bits set");
    watch_pulse_a: assert property (watch_irq |=> !watch_irq [*8])
        else $error("watch pulse too long");
    ivl_pulse_a: assert property (interval_irq |=> !interval_irq [*8])
        else $error("interval pulse too long");
endmodule
bind watch_interval_timer watch_timer_props #(.ADDR_W(ADDR_W), .MAIN_DIV(MAIN_DIV))
    u_watch_timer_props (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sub_clk_pin, .watch_irq, .interval_irq, .irq);

// ===== sim/tb_watch_interval_timer.sv
// self-checking bench for the watch and interval timer
`timescale 1ns/1ps
`include "watch_timer_map.svh"
module tb_watch_interval_timer;
    import watch_timer_pkg::*;
    localparam int MAIN_DIV = 2;
    localparam int SUB_PER = 10;
    logic core_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic sub_clk_pin, watch_irq, interval_irq, irq;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    axi_resp_t s_axi_bresp, s_axi_rresp;
    int sub_div, failures, check_count;
    watch_interval_timer #(.MAIN_DIV(MAIN_DIV)) u_watch_interval_timer (.core_clk, .nrst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_clk_pin,
        .watch_irq, .interval_irq, .irq);
    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    // sub clock of ten core cycles, so every period figure is exact
    always @(posedge core_clk) begin
        sub_div <= (sub_div == SUB_PER / 2 - 1) ? 0 : sub_div + 1;
        if (sub_div == SUB_PER / 2 - 1) sub_clk_pin <= ~sub_clk_pin;
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            wrap_up();
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [15:0] idx, input reg8_t d, input axi_resp_t er);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        give_up(n, 100);
        check("write response", s_axi_bresp, er);
    endtask
    // one read, compared with the expected byte and response
    task automatic rd(input logic [15:0] idx, input reg8_t exp, input axi_resp_t er);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        give_up(n, 100);
        check("read data", s_axi_rdata, {24'h0, exp});
        check("read response", s_axi_rresp, er);
    endtask
    // cycles up to the next pulse of the chosen event
    task automatic wait_pulse(input bit watch, input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((watch ? watch_irq : interval_irq) !== 1'b1 && n < lim);
        give_up(n, lim);
    endtask
    task automatic t_reset_vals();
        rd(`WT_IDX_MODE, 8'h00, `WT_RESP_OKAY);
        rd(`WT_IDX_TSEL, 8'h00, `WT_RESP_OKAY);
        rd(`WT_IDX_STAT, 8'h00, `WT_RESP_OKAY);
    endtask
    task automatic t_reg_access();
        wr(`WT_IDX_MODE, 8'h0C, `WT_RESP_OKAY);
        rd(`WT_IDX_MODE, 8'h00, `WT_RESP_OKAY);
        wr(`WT_IDX_TSEL, 8'hFF, `WT_RESP_OKAY);
        rd(`WT_IDX_TSEL, 8'h01, `WT_RESP_OKAY);
        wr(`WT_IDX_STAT, 8'hFF, `WT_RESP_OKAY);
        rd(`WT_IDX_STAT, 8'h00, `WT_RESP_OKAY);
        wr(16'h0123, 8'h55, `WT_RESP_SLVERR);
        rd(16'h0123, 8'h00, `WT_RESP_SLVERR);
        rd(`WT_IDX_CLR, 8'h00, `WT_RESP_OKAY);
        s_axi_wstrb <= 4'hE;
        wr(`WT_IDX_MODE, 8'h51, `WT_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`WT_IDX_MODE, 8'h00, `WT_RESP_OKAY);
        wr(`WT_IDX_TSEL, 8'h00, `WT_RESP_OKAY);
    endtask
    task automatic t_interval_main();
        int n;
        wr(`WT_IDX_IEN, 8'h03, `WT_RESP_OKAY);
        rd(`WT_IDX_IEN, 8'h03, `WT_RESP_OKAY);
        for (int c = 0; c < 6; c++) begin
            wr(`WT_IDX_MODE, {1'b0, c[2:0], 4'h1}, `WT_RESP_OKAY);
            wait_pulse(1'b0, 2100, n);
            wait_pulse(1'b0, 2100, n);
            check("interval period", n, (32'd1 << (4 + c)) * MAIN_DIV);
        end
        wait_pulse(1'b0, 2100, n);
        repeat (3) @(posedge core_clk);
        check("irq raised", irq, 1'b1);
        rd(`WT_IDX_STAT, 8'h02, `WT_RESP_OKAY);
        wr(`WT_IDX_CLR, 8'h02, `WT_RESP_OKAY);
        rd(`WT_IDX_STAT, 8'h00, `WT_RESP_OKAY);
        wr(`WT_IDX_IEN, 8'h00, `WT_RESP_OKAY);
        check("irq masked", irq, 1'b0);
    endtask
    task automatic t_clock_select();
        int n;
        wr(`WT_IDX_MODE, 8'h81, `WT_RESP_OKAY);
        wait_pulse(1'b0, 2100, n);
        wait_pulse(1'b0, 2100, n);
        check("sub clock period", n, 16 * SUB_PER);
        wr(`WT_IDX_TSEL, 8'h01, `WT_RESP_OKAY);
        wait_pulse(1'b0, 2100, n);
        wait_pulse(1'b0, 2100, n);
        check("half sub period", n, 32 * SUB_PER);
        wr(`WT_IDX_MODE, 8'h01, `WT_RESP_OKAY);
        wait_pulse(1'b0, 2100, n);
        wait_pulse(1'b0, 2100, n);
        check("half select ignored", n, 16 * MAIN_DIV);
    endtask
    task automatic t_disable();
        int k;
        k = 0;
        wr(`WT_IDX_MODE, 8'h00, `WT_RESP_OKAY);
        repeat (600) begin
            @(posedge core_clk);
            if (interval_irq !== 1'b0 || watch_irq !== 1'b0) k++;
        end
        check("stopped timer events", k, 0);
    endtask
    task automatic t_watch();
        int n;
        wr(`WT_IDX_TSEL, 8'h00, `WT_RESP_OKAY);
        wr(`WT_IDX_IEN, 8'h03, `WT_RESP_OKAY);
        wr(`WT_IDX_MODE, 8'h03, `WT_RESP_OKAY);
        wait_pulse(1'b1, 40000, n);
        check("first watch delay", (n + 16) / 32, (512 + 16384) * MAIN_DIV / 32);
        wait_pulse(1'b1, 40000, n);
        check("watch period", n, 16384 * MAIN_DIV);
        repeat (3) @(posedge core_clk);
        check("watch irq level", irq, 1'b1);
        rd(`WT_IDX_STAT, 8'h03, `WT_RESP_OKAY);
        wr(`WT_IDX_MODE, 8'h00, `WT_RESP_OKAY);
        wr(`WT_IDX_CLR, 8'h03, `WT_RESP_OKAY);
        rd(`WT_IDX_STAT, 8'h00, `WT_RESP_OKAY);
        check("irq cleared", irq, 1'b0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        {core_clk, nrst, sub_clk_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {sub_div, failures, check_count} = '0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset_vals();
        t_reg_access();
        t_interval_main();
        t_clock_select();
        t_disable();
        t_watch();
        wrap_up();
    end
endmodule
